// File: rtl/hrp_edge_ctrl.sv
// hrp_edge_ctrl: fine edge control and register file of one pwm
// channel, reached over axi4-lite. assumes the time base supplies
// one-cycle counter zero / period pulses and coarse a/b signals.
// Operation
// [R1] swap bit exchanges outputs a and b
// [R2] auto-scale multiplies fine value by scale factor
// [R3] software pre-scaling keeps auto-scale cleared
// [R4] b select drives inverted a onto b
// [R5] load select picks zero, period or both
// [R6] source select picks compare/period or phase
// [R7] edge select: off, rise, fall, both
// [R8] configuration resets to all zeros
// [R9] fine compare bits 15-8, 32-bit combined access
// [R10] compare a shadow enable governs fine compare
// [R11] software writes zeros to reserved low bytes
// [R12] fine phase bits 15-8, low byte reads zero
// [R13] period and compare registers are shadowed; here period fine is written directly, only compare a is shadowed
// [R14] config writes need unlock, act on a only
// [R15] 8-bit step scale converts fine value to delay
// [R16] reserved load code performs no load
// [R17] off mode leaves coarse edges untouched
`timescale 1ns/1ps
module hrp_edge_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic write_unlock,
  input wire logic ctr_zero,
  input wire logic ctr_prd,
  input wire logic coarse_a,
  input wire logic coarse_b,
  output logic output_a,
  output logic output_b,
  output logic [7:0] fine_delay,
  output logic fine_rise_en,
  output logic fine_fall_en,
  output logic [15:0] compare_a_coarse_active
);
  import hrp_pkg::*;

  logic aw_got, w_got;
  logic [5:0] aw_idx;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [7:0] cfg;
  logic [15:0] cmp_ctrl;
  logic [7:0] compare_a_coarse_fine_sh, compare_a_coarse_fine_act;
  logic [15:0] compare_a_coarse_sh;
  logic [7:0] phase_fine;
  logic [7:0] period_fine;
  logic [7:0] step_scale;

  // write channel
  wire do_wr = aw_got && w_got && !s_axi_bvalid;
  wire [5:0] w_idx = aw_idx;
  wire lo_en = wstrb_q[1];
  wire hi_en = wstrb_q[3];
  // byte-wide fields in bits 7-0 follow byte lane 0, as on any axi data bus
  wire b0_en = wstrb_q[0];
  wire wr_cfg = do_wr && w_idx == IDX_EDGE_CFG;
  wire wr_step = do_wr && w_idx == IDX_STEP_SCALE;
  wire wr_cmpf = do_wr && (w_idx == IDX_COMPARE_A_COARSE_FINE ||
    w_idx == IDX_COMPARE_A_COARSE_FINE_M);
  wire wr_cmpc = do_wr && (w_idx == IDX_COMPARE_A_COARSE_COARSE ||
    w_idx == IDX_COMPARE_A_COARSE_COARSE_M);
  wire wr_prdf = do_wr && (w_idx == IDX_PERIOD_FINE ||
    w_idx == IDX_PERIOD_FINE_M);
  wire wr_phsf = do_wr && w_idx == IDX_PHASE_FINE;
  wire wr_cctl = do_wr && w_idx == IDX_CMP_CTRL;
  wire shadow_on = cmp_ctrl[CMP_SHADOW_BIT];
  wire [1:0] load_sel = cfg[CFG_LOAD_HI:CFG_LOAD_LO];
  wire [1:0] edge_sel = cfg[CFG_EDGE_HI:CFG_EDGE_LO];
  // reserved code 11 matches no event, so nothing loads
  wire load_evt = (load_sel == LOAD_ZERO && ctr_zero) ||
    (load_sel == LOAD_PRD && ctr_prd) ||
    (load_sel == LOAD_BOTH && (ctr_zero || ctr_prd)); // [R5] [R16]
  // index 8 / 0x2c carries fine low, coarse high for one access
  wire cmpf_pair = w_idx == IDX_COMPARE_A_COARSE_FINE || w_idx == IDX_COMPARE_A_COARSE_FINE_M;
  wire wf_en = wr_cmpf && lo_en;
  wire wc_en = (wr_cmpf && hi_en) || (wr_cmpc && lo_en); // [R9]
  wire [15:0] wc_val = cmpf_pair ? wdata_q[31:16] : wdata_q[15:0];
  wire known_w = w_idx <= IDX_COMPARE_B_VALUE || w_idx == IDX_EDGE_CFG ||
    w_idx == IDX_POWER || w_idx == IDX_STEP_SCALE ||
    (w_idx >= IDX_PERIOD_CTRL && w_idx <= IDX_COMPARE_A_COARSE_COARSE_M &&
    w_idx != 6'h29);

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_idx <= 6'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_idx <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known_w ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // protected configuration; cfg and step scale ignored while locked, cmp_ctrl always writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= CFG_RESET; // [R8]
      step_scale <= STEP_RESET;
      cmp_ctrl <= CMP_CTRL_RESET;
    end else begin
      if (wr_cfg && b0_en && write_unlock) begin
        cfg <= wdata_q[7:0]; // [R14]
      end
      if (wr_step && b0_en && write_unlock) begin
        step_scale <= wdata_q[7:0]; // [R14] [R15]
      end
      // the shadow enable sits in lane 0, the upper byte in lane 1
      if (wr_cctl && b0_en) begin
        cmp_ctrl[7:0] <= wdata_q[7:0];
      end
      if (wr_cctl && lo_en) begin
        cmp_ctrl[15:8] <= wdata_q[15:8];
      end
    end
  end

  // compare a: shadow and active, same enable for both parts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_a_coarse_fine_sh <= 8'h00;
      compare_a_coarse_fine_act <= 8'h00;
      compare_a_coarse_sh <= 16'h0000;
      compare_a_coarse_active <= 16'h0000;
      phase_fine <= 8'h00;
      period_fine <= 8'h00;
    end else begin
      // in the load cycle active takes the old shadow; a software write lands in the shadow
      if (shadow_on && load_evt) begin
        compare_a_coarse_fine_act <= compare_a_coarse_fine_sh; // [R5] [R13]
        compare_a_coarse_active <= compare_a_coarse_sh;
      end
      if (wf_en) begin
        compare_a_coarse_fine_sh <= wdata_q[15:8]; // [R9] [R10]
        if (!shadow_on) begin
          compare_a_coarse_fine_act <= wdata_q[15:8]; // [R10]
        end
      end
      if (wc_en) begin
        compare_a_coarse_sh <= wc_val;
        if (!shadow_on) begin
          compare_a_coarse_active <= wc_val;
        end
      end
      if (wr_phsf && lo_en) begin
        phase_fine <= wdata_q[15:8]; // [R12]
      end
      if (wr_prdf && lo_en) begin
        period_fine <= wdata_q[15:8]; // [R13]
      end
    end
  end

  // read channel: one-cycle registered answer
  wire [5:0] r_idx = s_axi_araddr[7:2];
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (r_idx)
      IDX_EDGE_CFG: rd_mux = {24'h000000, cfg};
      IDX_STEP_SCALE: rd_mux = {24'h000000, step_scale};
      IDX_CMP_CTRL: rd_mux = {16'h0000, cmp_ctrl};
      // reserved low bytes read as zero
      IDX_COMPARE_A_COARSE_FINE: rd_mux = {compare_a_coarse_sh, compare_a_coarse_fine_sh, 8'h00}; // [R9]
      IDX_COMPARE_A_COARSE_COARSE: rd_mux = {16'h0000, compare_a_coarse_sh};
      IDX_COMPARE_A_COARSE_COARSE_M: rd_mux = {16'h0000, compare_a_coarse_sh};
      IDX_PHASE_FINE: rd_mux = {16'h0000, phase_fine, 8'h00}; // [R12]
      IDX_PERIOD_FINE: rd_mux = {16'h0000, period_fine, 8'h00};
      IDX_TB_CTRL, IDX_TB_STATE, IDX_PHASE_COARSE, IDX_COUNTER,
      IDX_PERIOD_COARSE, IDX_COMPARE_B_VALUE, IDX_POWER, IDX_PERIOD_CTRL,
      IDX_PERIOD_FINE_M, IDX_PERIOD_COARSE_M,
      IDX_COMPARE_A_COARSE_FINE_M: rd_mux = 32'h0000_0000;
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // fine value source and scaling
  wire src_phase = cfg[CFG_SRC];
  wire [7:0] fine_src = src_phase ? phase_fine :
    (edge_sel == EDGE_BOTH ? period_fine : compare_a_coarse_fine_act); // [R6] [R7]
  wire [15:0] scaled = fine_src * step_scale;
  wire [7:0] next_fine_delay = edge_sel == EDGE_OFF ? 8'h00 :
    (cfg[CFG_AUTO] ? scaled[15:8] : fine_src); // [R2] [R15] [R17]
  // outputs: b select first, then swap; only channel a gets fine edges
  wire b_sel = cfg[CFG_BSEL] ? !coarse_a : coarse_b; // [R4]
  wire next_a = cfg[CFG_SWAP] ? b_sel : coarse_a; // [R1]
  wire next_b = cfg[CFG_SWAP] ? coarse_a : b_sel; // [R1]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_a <= 1'b0;
      output_b <= 1'b0;
      fine_delay <= 8'h00;
      fine_rise_en <= 1'b0;
      fine_fall_en <= 1'b0;
    end else begin
      output_a <= next_a;
      output_b <= next_b;
      fine_delay <= next_fine_delay;
      fine_rise_en <= edge_sel[0]; // [R7] [R14]
      fine_fall_en <= edge_sel[1]; // [R7]
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_swap;
    cfg[CFG_SWAP] |=> output_b == $past(coarse_a);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong"); // [R1]

  property p_binv;
    !cfg[CFG_SWAP] && cfg[CFG_BSEL] |=> output_b == !$past(coarse_a);
  endproperty
  a_binv: assert property (p_binv) else $error("b invert wrong"); // [R4]

  property p_off;
    edge_sel == EDGE_OFF |=> fine_delay == 8'h00 && !fine_rise_en
      && !fine_fall_en;
  endproperty
  a_off: assert property (p_off) else $error("off not clean"); // [R17]

  property p_auto;
    edge_sel != EDGE_OFF && cfg[CFG_AUTO] |=>
      fine_delay == $past(scaled[15:8]);
  endproperty
  a_auto: assert property (p_auto) else $error("scale wrong"); // [R2]

  property p_noload;
    load_sel == 2'h3 && !wf_en |=> $stable(compare_a_coarse_fine_act);
  endproperty
  a_noload: assert property (p_noload) else $error("bad load"); // [R16]

  property p_load;
    shadow_on && load_evt && !wf_en |=>
      compare_a_coarse_fine_act == $past(compare_a_coarse_fine_sh);
  endproperty
  a_load: assert property (p_load) else $error("no load"); // [R5]

  property p_direct;
    !shadow_on && wf_en |=> compare_a_coarse_fine_act == $past(wdata_q[15:8]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct"); // [R10]

  property p_lock;
    wr_cfg && !write_unlock |=> $stable(cfg);
  endproperty
  a_lock: assert property (p_lock) else $error("lock broken"); // [R14]

  property p_rd;
    s_axi_arvalid && s_axi_arready && r_idx == IDX_PHASE_FINE |=>
      s_axi_rvalid && s_axi_rdata[7:0] == 8'h00;
  endproperty
  a_rd: assert property (p_rd) else $error("phase low byte"); // [R12]

  property p_plain;
    !cfg[CFG_SWAP] && !cfg[CFG_BSEL] |=>
      output_a == $past(coarse_a) && output_b == $past(coarse_b);
  endproperty
  a_plain: assert property (p_plain) else $error("plain wrong"); // [R1]

  property p_swap_a;
    cfg[CFG_SWAP] && !cfg[CFG_BSEL] |=> output_a == $past(coarse_b);
  endproperty
  a_swap_a: assert property (p_swap_a) else $error("a swap wrong"); // [R1]

  property p_phase;
    edge_sel != EDGE_OFF && !cfg[CFG_AUTO] && cfg[CFG_SRC] |=>
      fine_delay == $past(phase_fine);
  endproperty
  a_phase: assert property (p_phase) else $error("phase src"); // [R6]

  property p_period;
    edge_sel == EDGE_BOTH && !cfg[CFG_AUTO] && !cfg[CFG_SRC] |=>
      fine_delay == $past(period_fine);
  endproperty
  a_period: assert property (p_period) else $error("period src"); // [R7]

  property p_cmpsrc;
    (edge_sel == EDGE_RISE || edge_sel == EDGE_FALL) && !cfg[CFG_AUTO] &&
      !cfg[CFG_SRC] |=> fine_delay == $past(compare_a_coarse_fine_act);
  endproperty
  a_cmpsrc: assert property (p_cmpsrc) else $error("cmp src"); // [R7]

  property p_edge_en;
    edge_sel != EDGE_OFF |=> fine_rise_en == $past(edge_sel[0]) &&
      fine_fall_en == $past(edge_sel[1]);
  endproperty
  a_edge_en: assert property (p_edge_en) else $error("edge enable"); // [R7]

  property p_slock;
    wr_step && !write_unlock |=> $stable(step_scale);
  endproperty
  a_slock: assert property (p_slock) else $error("step lock"); // [R14]

  property p_cfg_wr;
    wr_cfg && write_unlock && b0_en |=> cfg == $past(wdata_q[7:0]);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("cfg write"); // [R14]

  property p_hold;
    shadow_on && !load_evt |=> $stable(compare_a_coarse_fine_act);
  endproperty
  a_hold: assert property (p_hold) else $error("fine moved"); // [R10]

  property p_coarse;
    shadow_on && load_evt |=> compare_a_coarse_active == $past(compare_a_coarse_sh);
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse load"); // [R13]

  c_load: cover property (shadow_on && load_evt);
  c_zero: cover property (shadow_on && ctr_zero && load_sel == LOAD_ZERO);
  c_lock: cover property (wr_cfg && !write_unlock);
  c_swap: cover property (cfg[CFG_SWAP] && cfg[CFG_BSEL]);
  c_pair: cover property (wr_cmpf && wstrb_q == 4'hf);
endmodule : hrp_edge_ctrl

// File: rtl/hrp_pkg.sv
// hrp_pkg: register indices, field positions and reset values
// for the fine edge control block; shared by design and bench.
package hrp_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_TB_CTRL = 6'h00;
  localparam logic [5:0] IDX_TB_STATE = 6'h01;
  localparam logic [5:0] IDX_PHASE_FINE = 6'h02;
  localparam logic [5:0] IDX_PHASE_COARSE = 6'h03;
  localparam logic [5:0] IDX_COUNTER = 6'h04;
  localparam logic [5:0] IDX_PERIOD_COARSE = 6'h05;
  localparam logic [5:0] IDX_PERIOD_FINE = 6'h06;
  localparam logic [5:0] IDX_CMP_CTRL = 6'h07;
  localparam logic [5:0] IDX_COMPARE_A_COARSE_FINE = 6'h08;
  localparam logic [5:0] IDX_COMPARE_A_COARSE_COARSE = 6'h09;
  localparam logic [5:0] IDX_COMPARE_B_VALUE = 6'h0a;
  localparam logic [5:0] IDX_EDGE_CFG = 6'h20;
  localparam logic [5:0] IDX_POWER = 6'h21;
  localparam logic [5:0] IDX_STEP_SCALE = 6'h26;
  localparam logic [5:0] IDX_PERIOD_CTRL = 6'h28;
  localparam logic [5:0] IDX_PERIOD_FINE_M = 6'h2a;
  localparam logic [5:0] IDX_PERIOD_COARSE_M = 6'h2b;
  localparam logic [5:0] IDX_COMPARE_A_COARSE_FINE_M = 6'h2c;
  localparam logic [5:0] IDX_COMPARE_A_COARSE_COARSE_M = 6'h2d;
  // fine_edge_config fields
  localparam int CFG_SWAP = 7;
  localparam int CFG_AUTO = 6;
  localparam int CFG_BSEL = 5;
  localparam int CFG_LOAD_HI = 4;
  localparam int CFG_LOAD_LO = 3;
  localparam int CFG_SRC = 2;
  localparam int CFG_EDGE_HI = 1;
  localparam int CFG_EDGE_LO = 0;
  // compare_control bit that enables compare A shadowing
  localparam int CMP_SHADOW_BIT = 4;
  localparam logic [1:0] LOAD_ZERO = 2'h0;
  localparam logic [1:0] LOAD_PRD = 2'h1;
  localparam logic [1:0] LOAD_BOTH = 2'h2;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // fine fields occupy bits 15-8 of their 16-bit register
  localparam int FINE_LSB = 8;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] CMP_CTRL_RESET = 16'h0000;
  localparam logic [7:0] STEP_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : hrp_pkg

// File: verification/hrp_load_model.sv
// hrp_load_model: stand-in for the power stage fed by outputs a and b.
// assumes both outputs are registered on aclk by the block.
`timescale 1ns/1ps
module hrp_load_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic output_a,
  input wire logic output_b,
  output logic [7:0] a_rises,
  output logic [7:0] b_rises
);
  logic last_a;
  logic last_b;
  // counts turn-on events of the switches driven by outputs a and b
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_a <= 1'b0;
      last_b <= 1'b0;
      a_rises <= 8'h00;
      b_rises <= 8'h00;
    end else begin
      last_a <= output_a;
      last_b <= output_b;
      if (output_a && !last_a) begin
        a_rises <= a_rises + 8'h01;
      end
      if (output_b && !last_b) begin
        b_rises <= b_rises + 8'h01;
      end
    end
  end
endmodule : hrp_load_model

// File: verification/tb_top.sv
// tb_top: register-level tests of the fine edge control block.
// assumes an axi4-lite slave with byte address four times the index.
`timescale 1ns/1ps
module tb_top;
  import hrp_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid;
  logic arready, rvalid, unlock = 1'b1, zero = 1'b0, prd = 1'b0;
  logic ca = 1'b0, cb = 1'b0, oa, ob, rise_en, fall_en;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] delay, a_rises, b_rises;
  logic [15:0] compare_a_coarse;
  logic [31:0] rd_v;
  int failures = 0, compares = 0, cycles = 0;
  logic [7:0] cfg;
  logic eb;
  always #50 aclk = ~aclk;
  hrp_edge_ctrl i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .write_unlock(unlock),
    .ctr_zero(zero), .ctr_prd(prd), .coarse_a(ca), .coarse_b(cb),
    .output_a(oa), .output_b(ob), .fine_delay(delay),
    .fine_rise_en(rise_en), .fine_fall_en(fall_en), .compare_a_coarse_active(compare_a_coarse));
  hrp_load_model i_load (.aclk(aclk), .aresetn(aresetn), .output_a(oa),
    .output_b(ob), .a_rises(a_rises), .b_rises(b_rises));
  task automatic complete_run;
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // flags are sampled mid-cycle, so no race with the edge that moves them
  task automatic wr(logic [5:0] i, logic [31:0] d);
    logic a, w, b;
    a = 1'b1; w = 1'b1; b = 1'b0;
    @(posedge aclk);
    awaddr <= {i, 2'h0}; wdata <= d;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      a = a && !awready; w = w && !wready; b = bvalid; resp = bresp;
      @(posedge aclk);
      awvalid <= a; wvalid <= w;
    end
    bready <= 1'b0;
  endtask : wr
  task automatic rd(logic [5:0] i);
    logic a, r;
    a = 1'b1; r = 1'b0;
    @(posedge aclk);
    araddr <= {i, 2'h0}; arvalid <= 1'b1; rready <= 1'b1;
    while (!r) begin
      @(negedge aclk);
      a = a && !arready; r = rvalid; rd_v = rdata; resp = rresp;
      @(posedge aclk);
      arvalid <= a;
    end
    rready <= 1'b0;
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask : settle
  task automatic pulse(logic z, logic p);
    @(posedge aclk);
    zero <= z; prd <= p;
    @(posedge aclk);
    zero <= 1'b0; prd <= 1'b0;
    settle();
  endtask : pulse
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    rd(IDX_EDGE_CFG);
    chk("cfg_reset", {24'h0, CFG_RESET}, rd_v);
    chk("rise_off", 1'b0, rise_en);
    rd(6'h3f);
    chk("unmapped", RESP_SLVERR, resp);
    wr(6'h29, 32'h1);
    chk("wr_unmapped", RESP_SLVERR, resp);
    for (int e = 0; e < 4; e++) begin
      wr(IDX_EDGE_CFG, e);
      settle();
      chk("edge_en", e, {fall_en, rise_en});
    end
    for (int k = 0; k < 16; k++) begin
      cfg = 8'h00;
      cfg[CFG_SWAP] = k[3];
      cfg[CFG_BSEL] = k[2];
      wr(IDX_EDGE_CFG, cfg);
      @(posedge aclk);
      ca <= k[1]; cb <= k[0];
      settle();
      eb = k[2] ? !k[1] : k[0];
      chk("out_ab", k[3] ? {eb, k[1]} : {k[1], eb}, {oa, ob});
    end
    chk("load_seen", 1'b1, |a_rises);
    chk("b_seen", 1'b1, |b_rises);
    @(posedge aclk);
    unlock <= 1'b0;
    wr(IDX_EDGE_CFG, 32'hff);
    chk("lock_resp", RESP_OKAY, resp);
    rd(IDX_EDGE_CFG);
    chk("locked", cfg, rd_v);
    unlock <= 1'b1;
    wstrb <= 4'h2;
    wr(IDX_EDGE_CFG, 32'hff);
    wstrb <= 4'hf;
    rd(IDX_EDGE_CFG);
    chk("lane0", cfg, rd_v);
    wr(IDX_CMP_CTRL, 32'h1 << CMP_SHADOW_BIT);
    wr(IDX_EDGE_CFG, (3 << CFG_LOAD_LO) | EDGE_RISE);
    wr(IDX_COMPARE_A_COARSE_FINE, 32'h0123_4000);
    pulse(1'b1, 1'b1);
    chk("no_load", 16'h0, compare_a_coarse);
    wr(IDX_EDGE_CFG, (LOAD_PRD << CFG_LOAD_LO) | EDGE_RISE);
    pulse(1'b1, 1'b0);
    chk("prd_only", 16'h0, compare_a_coarse);
    pulse(1'b0, 1'b1);
    chk("prd_load", 16'h0123, compare_a_coarse);
    chk("fine_cmp", 8'h40, delay);
    wr(IDX_EDGE_CFG, EDGE_RISE);
    wr(IDX_COMPARE_A_COARSE_FINE, 32'h0321_5000);
    pulse(1'b0, 1'b1);
    chk("zero_wait", 16'h0123, compare_a_coarse);
    pulse(1'b1, 1'b0);
    chk("zero_load", 16'h0321, compare_a_coarse);
    chk("zero_fine", 8'h50, delay);
    wr(IDX_STEP_SCALE, 32'h80);
    wr(IDX_EDGE_CFG, (1 << CFG_AUTO) | EDGE_FALL);
    settle();
    chk("auto", 8'h28, delay);
    wr(IDX_PHASE_FINE, 32'h7700);
    wr(IDX_EDGE_CFG, (1 << CFG_SRC) | EDGE_BOTH);
    settle();
    chk("phase_src", 8'h77, delay);
    rd(IDX_PHASE_FINE);
    chk("phase_rd", 32'h7700, rd_v);
    chk("rd_resp", RESP_OKAY, resp);
    wr(IDX_PERIOD_FINE_M, 32'h3300);
    wr(IDX_EDGE_CFG, EDGE_BOTH);
    settle();
    chk("period_src", 8'h33, delay);
    rd(IDX_PERIOD_FINE);
    chk("period_rd", 32'h3300, rd_v);
    wr(IDX_CMP_CTRL, 32'h0);
    wr(IDX_EDGE_CFG, (LOAD_BOTH << CFG_LOAD_LO) | EDGE_RISE);
    wr(IDX_COMPARE_A_COARSE_FINE, 32'h0456_1000);
    settle();
    chk("direct", 16'h0456, compare_a_coarse);
    chk("direct_f", 8'h10, delay);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    chk("rst_delay", 8'h00, delay);
    rd(IDX_EDGE_CFG);
    chk("rst_cfg", {24'h0, CFG_RESET}, rd_v);
    complete_run();
  end
endmodule : tb_top
